//--- common/dcrq_cfg_regs.svh
// Register offsets, field positions and reset values of the config bank
`ifndef DCRQ_CFG_REGS_SVH
`define DCRQ_CFG_REGS_SVH
// Printed offsets are register indices; byte address is four times index
`define DCRQ_IDX_PHASE_OFF0 12'h033D
`define DCRQ_IDX_PHASE_OFF1 12'h033E
`define DCRQ_IDX_PHASE_OFF2 12'h033F
`define DCRQ_IDX_PHASE_OFF3 12'h0340
`define DCRQ_IDX_PHASE_OFF4 12'h0341
`define DCRQ_IDX_PHASE_OFF5 12'h0342
`define DCRQ_IDX_TEST_ROUTE 12'h0347
`define DCRQ_IDX_DECIM_CTRL 12'h041E
`define DCRQ_IDX_BW_MODE 12'h0420
`define DCRQ_IDX_TUNING 12'h0422
`define DCRQ_PHASE_BYTES 6
`define DCRQ_BIT_TEST_I 0
`define DCRQ_BIT_TEST_Q 2
`define DCRQ_BIT_DECIM_EN 0
`define DCRQ_BIT_DECIM_HP 7
`define DCRQ_DECIM_RW_MASK 8'hBF
`define DCRQ_BW_MODE_LSB 1
`define DCRQ_BW_MODE_MSB 3
`define DCRQ_BW_RW_MASK 8'h8E
`define DCRQ_TUNING_MASK 8'h3F
`define DCRQ_TEST_RW_MASK 8'h05
`define DCRQ_RESET_BYTE 8'h00
`endif

//--- common/dcrq_pkg.sv
// Types shared by the downconverter and requantizer config bank
package dcrq_pkg;
  typedef logic [7:0] dcrq_byte_t;
  typedef logic [11:0] dcrq_index_t;
  typedef enum logic [2:0] {
    DCRQ_BW_21PCT = 3'h0,
    DCRQ_BW_28PCT = 3'h1
  } dcrq_bw_e;
endpackage : dcrq_pkg

//--- verilog/dcrq_cfg.sv
// APB register bank for downconverter phase offset and requantizer setup
// Operation
// - Phase offset bytes 15:8 to 47:40 sit in five RW registers, reset zero.
// - Phase offset byte 7:0 sits in the register just before them.
// - Test bit 2 routes downconverter Q samples through B/D test block.
// - Test bit 0 routes downconverter I samples through A/C test block.
// - Decimation control bit 7 chooses low-pass (0) or high-pass (1).
// - Decimation control bit 0 enables the decimate-by-2 stage, reset off.
// - Three-bit bandwidth mode and six-bit tuning word, both reset zero.
`timescale 1ns/10ps
`default_nettype none
`include "dcrq_cfg_regs.svh"

module dcrq_cfg (
  input wire logic sys_clk_in, // 100 MHz clock
  input wire logic rst_in, // Synchronous reset, active high
  input wire logic psel_in, // APB select
  input wire logic penable_in, // APB access phase
  input wire logic pwrite_in, // APB write
  input wire logic [15:0] paddr_in, // APB byte address
  input wire logic [31:0] pwdata_in, // APB write data
  output logic [31:0] prdata_out, // APB read data
  output logic pready_out, // APB ready
  output logic pslverr_out, // APB error on unmapped address
  output logic [47:0] phase_offset_out, // Downconverter NCO phase offset
  output logic test_route_i_out, // I samples through A/C test block
  output logic test_route_q_out, // Q samples through B/D test block
  output logic decim_enable_out, // Requantizer decimate-by-2 on
  output logic decim_high_pass_out, // 1 high-pass, 0 low-pass
  output dcrq_pkg::dcrq_bw_e bw_mode_out, // Requantizer bandwidth mode
  output logic [5:0] tuning_word_out // Requantizer tuning word
);
  import dcrq_pkg::*;

  dcrq_byte_t phase_reg [`DCRQ_PHASE_BYTES];
  dcrq_byte_t test_reg;
  dcrq_byte_t decim_reg;
  dcrq_byte_t bw_reg;
  dcrq_byte_t tuning_reg;
  dcrq_index_t idx;
  logic aligned;
  logic setup;
  logic wr_ok;
  logic hit;
  logic [2:0] phase_sel;
  logic phase_hit;
  dcrq_byte_t rd_byte;
  dcrq_byte_t wbyte;

  // Decode index from word address; misaligned bytes are treated unmapped
  assign idx = paddr_in[13:2];
  assign aligned = (paddr_in[1:0] == 2'h0) && (paddr_in[15:14] == 2'h0);
  assign setup = psel_in && !penable_in;
  assign wbyte = pwdata_in[7:0];
  assign phase_hit = aligned && idx >= `DCRQ_IDX_PHASE_OFF0
    && idx <= `DCRQ_IDX_PHASE_OFF5;
  assign phase_sel = 3'(idx - `DCRQ_IDX_PHASE_OFF0);

  // Read mux; reserved bits read zero
  always_comb begin
    rd_byte = `DCRQ_RESET_BYTE;
    hit = 1'b1;
    if (phase_hit) begin
      rd_byte = phase_reg[phase_sel];
    end else if (aligned && idx == `DCRQ_IDX_TEST_ROUTE) begin
      rd_byte = test_reg;
    end else if (aligned && idx == `DCRQ_IDX_DECIM_CTRL) begin
      rd_byte = decim_reg;
    end else if (aligned && idx == `DCRQ_IDX_BW_MODE) begin
      rd_byte = bw_reg;
    end else if (aligned && idx == `DCRQ_IDX_TUNING) begin
      rd_byte = tuning_reg;
    end else begin
      hit = 1'b0;
    end
  end

  // Zero-wait answer: pready rises in the access phase of each transfer
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end else begin
      pready_out <= setup;
      pslverr_out <= setup && !hit;
      if (setup && !pwrite_in) begin
        prdata_out <= {24'h00_0000, rd_byte};
      end
    end
  end

  // Write commits at the access edge where pready is seen high
  assign wr_ok = psel_in && penable_in && pready_out && pwrite_in;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < `DCRQ_PHASE_BYTES; i++) begin
        phase_reg[i] <= `DCRQ_RESET_BYTE;
      end
    end else if (wr_ok && phase_hit) begin
      phase_reg[phase_sel] <= wbyte;
    end
  end

  // Test routing register, only bits 2 and 0 writable
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      test_reg <= `DCRQ_RESET_BYTE;
    end else if (wr_ok && aligned && idx == `DCRQ_IDX_TEST_ROUTE) begin
      test_reg <= wbyte & `DCRQ_TEST_RW_MASK;
    end
  end

  // Decimation control; bit 6 is read-only zero
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      decim_reg <= `DCRQ_RESET_BYTE;
    end else if (wr_ok && aligned && idx == `DCRQ_IDX_DECIM_CTRL) begin
      decim_reg <= wbyte & `DCRQ_DECIM_RW_MASK;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      bw_reg <= `DCRQ_RESET_BYTE;
      tuning_reg <= `DCRQ_RESET_BYTE;
    end else if (wr_ok && aligned) begin
      if (idx == `DCRQ_IDX_BW_MODE) begin
        bw_reg <= wbyte & `DCRQ_BW_RW_MASK;
      end
      if (idx == `DCRQ_IDX_TUNING) begin
        tuning_reg <= wbyte & `DCRQ_TUNING_MASK;
      end
    end
  end

  // Datapath-facing fields, registered so outputs come from flops
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      phase_offset_out <= 48'h0000_0000_0000;
      test_route_i_out <= 1'b0;
      test_route_q_out <= 1'b0;
      decim_enable_out <= 1'b0;
      decim_high_pass_out <= 1'b0;
      bw_mode_out <= DCRQ_BW_21PCT;
      tuning_word_out <= 6'h00;
    end else begin
      // Assemble the 48-bit offset, high byte first, phase_reg[0] in bits 7:0
      phase_offset_out <= {phase_reg[5], phase_reg[4], phase_reg[3],
                           phase_reg[2], phase_reg[1], phase_reg[0]};
      test_route_i_out <= test_reg[`DCRQ_BIT_TEST_I];
      test_route_q_out <= test_reg[`DCRQ_BIT_TEST_Q];
      decim_enable_out <= decim_reg[`DCRQ_BIT_DECIM_EN];
      decim_high_pass_out <= decim_reg[`DCRQ_BIT_DECIM_HP];
      bw_mode_out <= dcrq_bw_e'(bw_reg[`DCRQ_BW_MODE_MSB:`DCRQ_BW_MODE_LSB]);
      tuning_word_out <= tuning_reg[5:0];
    end
  end

  // Assertions
  // Low byte lands
  a_phase_low_byte: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    wr_ok && aligned && idx == `DCRQ_IDX_PHASE_OFF0
    |=> ##1 phase_offset_out[7:0] == $past(wbyte, 2))
    else $error("phase low byte not stored");

  a_phase_high_byte: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    wr_ok && aligned && idx == `DCRQ_IDX_PHASE_OFF5
    |=> ##1 phase_offset_out[47:40] == $past(wbyte, 2))
    else $error("phase high byte not stored");

  a_route_q_bit: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    wr_ok && aligned && idx == `DCRQ_IDX_TEST_ROUTE
    |=> ##1 test_route_q_out == $past(wbyte[2], 2))
    else $error("Q routing wrong");

  a_route_i_bit: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    wr_ok && aligned && idx == `DCRQ_IDX_TEST_ROUTE
    |=> ##1 test_route_i_out == $past(wbyte[0], 2))
    else $error("I routing wrong");

  a_filter_select: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    wr_ok && aligned && idx == `DCRQ_IDX_DECIM_CTRL
    |=> ##1 decim_high_pass_out == $past(wbyte[7], 2))
    else $error("filter response wrong");

  a_decim_enable: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    wr_ok && aligned && idx == `DCRQ_IDX_DECIM_CTRL
    |=> ##1 decim_enable_out == $past(wbyte[0], 2))
    else $error("decimator enable wrong");

  a_bw_mode_field: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    wr_ok && aligned && idx == `DCRQ_IDX_BW_MODE
    |=> ##1 bw_mode_out == $past(wbyte[3:1], 2))
    else $error("bandwidth mode wrong");

  a_tuning_field: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    wr_ok && aligned && idx == `DCRQ_IDX_TUNING
    |=> ##1 tuning_word_out == $past(wbyte[5:0], 2))
    else $error("tuning word wrong");

  a_reset_clear: assert property (
    @(posedge sys_clk_in)
    rst_in |=> ##1 phase_offset_out == 48'h0000_0000_0000
    && !decim_enable_out)
    else $error("fields not cleared by reset");

  // Ready is a one-cycle pulse
  a_ready_timing: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    setup |=> pready_out ##1 !pready_out)
    else $error("pready not single cycle");

  // No ready without a setup phase
  a_ready_idle: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    !setup |=> !pready_out)
    else $error("pready without setup");

  // Unmapped or misaligned access flags an error
  a_err_unmapped: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    setup && !hit |=> pready_out && pslverr_out)
    else $error("no error on unmapped access");

  // Mapped access never flags an error
  a_err_mapped: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    setup && hit |=> !pslverr_out)
    else $error("error on mapped access");

  // Only the low byte of read data carries a register
  a_read_upper_zero: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    setup && !pwrite_in |=> prdata_out[31:8] == 24'h00_0000)
    else $error("read data upper bits set");

  // Unmapped reads return zero
  a_read_unmapped_zero: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    setup && !pwrite_in && !hit |=> prdata_out == 32'h0000_0000)
    else $error("unmapped read not zero");

  a_misalign_ignored: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    wr_ok && !aligned |=> ##1 $stable(phase_offset_out))
    else $error("misaligned write changed offset");

  a_route_reserved: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    setup && !pwrite_in && aligned && idx == `DCRQ_IDX_TEST_ROUTE
    |=> (prdata_out[7:0] & ~`DCRQ_TEST_RW_MASK) == 8'h00)
    else $error("reserved routing bits not zero");

  // Bit 6 of decimation control reads zero
  a_decim_ro_bit: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    setup && !pwrite_in && aligned && idx == `DCRQ_IDX_DECIM_CTRL
    |=> !prdata_out[6])
    else $error("read-only decimation bit set");

  a_bw_reserved: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    setup && !pwrite_in && aligned && idx == `DCRQ_IDX_BW_MODE
    |=> (prdata_out[7:0] & ~`DCRQ_BW_RW_MASK) == 8'h00)
    else $error("reserved mode bits not zero");

  a_tuning_reserved: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    setup && !pwrite_in && aligned && idx == `DCRQ_IDX_TUNING
    |=> prdata_out[7:6] == 2'h0)
    else $error("upper tuning bits not zero");

  // Mode and tuning cleared by reset
  a_reset_requant: assert property (
    @(posedge sys_clk_in)
    rst_in |=> ##1 tuning_word_out == 6'h00
    && bw_mode_out == DCRQ_BW_21PCT)
    else $error("requantizer fields not cleared");

  // Routing and filter choice cleared by reset
  a_reset_routing: assert property (
    @(posedge sys_clk_in)
    rst_in |=> ##1 !test_route_i_out && !test_route_q_out
    && !decim_high_pass_out)
    else $error("routing not cleared by reset");

  // Covers
  c_phase_write: cover property (@(posedge sys_clk_in) wr_ok && phase_hit);
  c_decim_on: cover property (@(posedge sys_clk_in) $rose(decim_enable_out));
  c_bad_addr: cover property (@(posedge sys_clk_in) pslverr_out);
  c_misalign_write: cover property (@(posedge sys_clk_in) wr_ok && !aligned);
  c_read: cover property (@(posedge sys_clk_in)
    pready_out && !pwrite_in && psel_in);
endmodule // dcrq_cfg
`default_nettype wire

//--- tb/tb_dcrq_cfg.sv
// Self-checking APB bench for the downconverter and requantizer config bank
`timescale 1ns/10ps
`default_nettype none
`include "dcrq_cfg_regs.svh"
module tb_dcrq_cfg;
  import dcrq_pkg::*;
  logic sys_clk_in, rst_in, psel, penable, pwrite, pready, pslverr, rerr;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [47:0] phase;
  logic ti, tq, de, dh;
  dcrq_bw_e bw;
  logic [5:0] tw;
  int mismatches, checks_done, k;
  logic [11:0] idx_list [10] = '{`DCRQ_IDX_PHASE_OFF0, `DCRQ_IDX_PHASE_OFF1,
    `DCRQ_IDX_PHASE_OFF2, `DCRQ_IDX_PHASE_OFF3, `DCRQ_IDX_PHASE_OFF4,
    `DCRQ_IDX_PHASE_OFF5, `DCRQ_IDX_TEST_ROUTE, `DCRQ_IDX_DECIM_CTRL,
    `DCRQ_IDX_BW_MODE, `DCRQ_IDX_TUNING};
  dcrq_cfg i_dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .phase_offset_out(phase),
    .test_route_i_out(ti), .test_route_q_out(tq), .decim_enable_out(de),
    .decim_high_pass_out(dh), .bw_mode_out(bw), .tuning_word_out(tw));
  // Clock at 100 MHz
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  function automatic logic [15:0] ba(input logic [11:0] i);
    return {2'b00, i, 2'b00};
  endfunction
  // Compare and count; unknowns never match
  task automatic chk(input string nm, input logic [47:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // APB transfer; holds request until pready is sampled high
  task automatic apb(input logic wr, input logic [15:0] a,
    input logic [31:0] d);
    int n;
    @(posedge sys_clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk("pready", 48'(pready), 48'h1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Write, read back and expect an accepted transfer
  task automatic wr_rd(input logic [11:0] i, input logic [7:0] d, exp);
    apb(1'b1, ba(i), {24'h00_0000, d});
    apb(1'b0, ba(i), 32'h0000_0000);
    chk("rdata", 48'(rdata), {40'h00_0000_0000, exp});
    chk("pslverr", 48'(rerr), 48'h0);
  endtask
  // Verdict in one place
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog well beyond the under two hundred cycles the tests need
  initial begin
    #200000;
    mismatches++;
    finish_test();
  end
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    rst_in = 1'b1;
    repeat (16) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    // Reset values of every register and field
    for (k = 0; k < 10; k++) begin
      apb(1'b0, ba(idx_list[k]), 32'h0000_0000);
      chk("reset", 48'(rdata), 48'h0);
    end
    chk("phase_rst", phase, 48'h0);
    chk("fields", 48'({ti, tq, de, dh, 3'(bw), tw}), 48'h0);
    $display("test reset done");
    // Phase offset bytes in order, lowest byte first
    for (k = 0; k < 6; k++) begin
      wr_rd(idx_list[k], 8'(8'hA0 + k), 8'(8'hA0 + k));
    end
    chk("phase", phase, 48'hA5A4_A3A2_A1A0);
    // Misaligned write must be refused and leave the byte alone
    apb(1'b1, ba(`DCRQ_IDX_PHASE_OFF1) + 16'h0001, 32'h0000_0055);
    chk("misalign_err", 48'(rerr), 48'h1);
    chk("misalign_phase", phase, 48'hA5A4_A3A2_A1A0);
    apb(1'b0, ba(`DCRQ_IDX_PHASE_OFF1), 32'h0000_0000);
    chk("misalign_keep", 48'(rdata), 48'hA1);
    $display("test phase done");
    // Test routing: reserved bits read back zero
    wr_rd(`DCRQ_IDX_TEST_ROUTE, 8'hFF, 8'h05);
    chk("route_iq", 48'({ti, tq}), 48'h3);
    wr_rd(`DCRQ_IDX_TEST_ROUTE, 8'h04, 8'h04);
    chk("route_iq", 48'({ti, tq}), 48'h1);
    $display("test routing done");
    // Decimation enable and high-pass choice, bit 6 read-only
    wr_rd(`DCRQ_IDX_DECIM_CTRL, 8'hFF, 8'hBF);
    chk("decim", 48'({de, dh}), 48'h3);
    wr_rd(`DCRQ_IDX_DECIM_CTRL, 8'h80, 8'h80);
    chk("decim", 48'({de, dh}), 48'h1);
    $display("test decimation done");
    // Both bandwidth codes, then the full tuning word
    for (k = 0; k < 2; k++) begin
      wr_rd(`DCRQ_IDX_BW_MODE, 8'h81 | 8'(k << 1), 8'h80 | 8'(k << 1));
      chk("bw_mode", 48'(bw), 48'(k));
    end
    wr_rd(`DCRQ_IDX_TUNING, 8'hFF, 8'h3F);
    chk("tuning", 48'(tw), 48'h3F);
    $display("test requantizer done");
    // Reset in mid-run clears every field that was set above
    @(posedge sys_clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    @(posedge sys_clk_in);
    chk("rerst_phase", phase, 48'h0);
    chk("rerst_fields", 48'({ti, tq, de, dh, 3'(bw), tw}), 48'h0);
    apb(1'b0, ba(`DCRQ_IDX_TUNING), 32'h0000_0000);
    chk("rerst_tuning", 48'(rdata), 48'h0);
    $display("test mid reset done");
    // Unmapped address answers with an error and zero data
    apb(1'b0, 16'h0004, 32'h0000_0000);
    chk("unmapped_err", 48'(rerr), 48'h1);
    chk("unmapped_data", 48'(rdata), 48'h0);
    $display("test unmapped done");
    finish_test();
  end
endmodule // tb_dcrq_cfg
`default_nettype wire
